// ### inc/event_mgmt_defines.vh
// Constants for the event-management instruction unit
`ifndef EVENT_MGMT_DEFINES_VH
`define EVENT_MGMT_DEFINES_VH

// Register offsets (word aligned byte addresses)
`define EM_OFS_INSTR       8'h00
`define EM_OFS_CONTROL     8'h04
`define EM_OFS_STATUS      8'h08
`define EM_OFS_MASK        8'h0c
`define EM_OFS_LATCH       8'h10
`define EM_OFS_RESULT      8'h14
`define EM_OFS_DREG0       8'h20

// Instruction opcodes, 16-bit words; low bits carry register or event number
`define EM_OP_QUIESCE      16'h0020
`define EM_OP_CSYNC        16'h0023
`define EM_OP_SSYNC        16'h0024
`define EM_OP_EMUFORCE     16'h0025
`define EM_OPH_DISABLE     13'h0006
`define EM_OPH_RESTORE     13'h0008
`define EM_OPH_FORCE       12'h009

// Control register fields
`define EM_CTL_SUPER       0
`define EM_CTL_EMU_EN      1
`define EM_CTL_WAKE        2
`define EM_CTL_PAR         3
`define EM_CTL_W           4

// Status register fields
`define EM_ST_BUSY         0
`define EM_ST_QUIET        1
`define EM_ST_PROT         2
`define EM_ST_EMU          3
`define EM_ST_SYNCREQ      4
`define EM_ST_ILLPAR       5

// Event numbers in the latch
`define EM_EV_EMU          0
`define EM_EV_RESET        1
`define EM_EV_NMI          2
`define EM_EV_EXC          3
`define EM_EV_HWERR        5

// Reset values
`define EM_MASK_RST        16'h001f
`define EM_CTL_RST         4'h1

// Write-back stage latency in clocks for the force-event instruction
`define EM_WB_DEPTH        3

`endif

// ### logic/event_management_instruction_unit.v
// Event-management instruction execution with a classic Wishbone register slave
// Function
// - Each event-management instruction is one 16-bit word.
// - After quiesce, execution resumes at the instruction following it.
// - Quiesce, disable, restore only in supervisor mode; else protection exception.
// - These instructions never issue in parallel with others.
// - Core sync resolves pending core work and drains the store buffer first.
// - Loads stay in order, stores stay in order; loads may pass stores.
// - Loads may run speculatively and may be cancelled or restarted.
// - Stores never reach memory speculatively.
// - During system sync, no further instruction issues until everything settles.
// - System sync also drains write buffers, then raises a sync request.
// - System sync completes only after the external acknowledge arrives.
// - Sync between write and read forces the write to complete first.
// - Force-emulation traps to emulation when enabled, else acts as no-op.
// - Emulation event outranks reset, NMI, exceptions and interrupts.
// - Disable copies mask into one of eight data registers, clears mask.
// - Cleared mask leaves NMI, reset, exceptions and emulation serviceable.
// - Restore loads the mask from a named data register.
// - Force-event carries a 4-bit number and sets that latch bit.
// - Latched software events are serviced by priority like hardware ones.
// - Event numbers: 1 reset, 2 NMI, 5 hw error, 6 timer, 7-15 general.
// - Force-event cannot raise exception or emulation events.
// - Force-event sets the latch no earlier than write-back.
// - Force-event only in supervisor mode; else protection exception.
`timescale 1ns/1ps
`default_nettype none
`include "event_mgmt_defines.vh"

module event_management_instruction_unit (
   input  wire        clk,
   input  wire        rst,
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [7:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output wire        wb_ack_o,
   input  wire        store_buf_empty,
   input  wire        write_buf_empty,
   input  wire        spec_pending,
   input  wire        load_pending,
   input  wire        store_pending,
   input  wire        hw_event_in_n_unused_tie,
   input  wire [15:0] hw_events,
   input  wire        wake_event,
   input  wire        sync_ack,
   output reg         sync_req,
   output wire        store_drain,
   output wire        write_drain,
   output wire        issue_stall,
   output wire        load_pass_ok,
   output wire        store_commit_ok,
   output reg         quiesced,
   output reg         emu_trap,
   output reg         prot_exc,
   output reg  [3:0]  event_take,
   output reg         event_valid,
   output reg  [15:0] resume_step
);

   // Limitations
   //  - one instruction in flight; the register bus is its only issue path
   //  - an instruction written while busy is acked but dropped, not queued
   //  - shared issue groups are flagged by software in control, not decoded
   //  - load and store pending hints arrive here but need no action
   //  - the event pick is a priority choice only; vectoring lives elsewhere
   //  - latch bits are never cleared on service; software writes ones
   //  - hardware events are level inputs and win over a same-cycle clear
   //  - no timeout on the sync handshake; a silent system stalls issue
   //  - soft wake is a control bit, so only the bus can end a soft sleep
   //  - the resume counter wraps silently after its last value
   //  - the data registers are full words, only the low half is a mask

   // Execution states
   //  IDLE   accepts one instruction from the bus
   //  CSYNC  waits for an empty store buffer and no open speculation
   //  WBUF   drains the write buffers toward the system side
   //  REQ    holds the sync request until the system acknowledges
   //  QUIET  stalls issue until a wake-up, hard or soft
   //  RAISE  counts down to write-back, then sets the latch bit
   //  Quiesce runs through both drains first so nothing is lost asleep
   //  Binary codes; the two unused codes fall back to idle
   //  Only IDLE counts as not busy, so issue stays held in all others
   localparam [2:0] S_IDLE  = 3'd0;
   localparam [2:0] S_CSYNC = 3'd1;
   localparam [2:0] S_WBUF  = 3'd2;
   localparam [2:0] S_REQ   = 3'd3;
   localparam [2:0] S_QUIET = 3'd4;
   localparam [2:0] S_RAISE = 3'd5;

   reg [2:0]  state_r;
   reg [2:0]  state_nxt;
   reg [15:0] interrupt_mask_register_r;
   reg [15:0] interrupt_latch_register_r;
   reg [3:0]  ctl_r;
   reg [15:0] instr_r;
   reg [15:0] result_r;
   reg        ack_r;
   reg        prot_sticky_r;
   reg        illpar_r;
   reg [3:0]  event_number_immediate_r;
   reg [1:0]  wb_cnt_r;
   reg [31:0] dreg_r [0:7];
   reg        quiet_pending_r;

   // Register map, word aligned
   //  INSTR   instruction word, ignored while busy
   //  CONTROL supervisor, emulation enable, soft wake, shared-issue flag
   //  STATUS  busy, asleep, protection and shared-issue sticky flags
   //  MASK    interrupt mask, low five events always let through
   //  LATCH   pending events, write ones to clear
   //  RESULT  done code of the last instruction
   //  DREG    eight data registers for mask save and restore
   wire        wb_req;
   wire        wb_wr;
   wire        busy;
   wire        instr_wr;
   wire [15:0] op;
   wire        sup_mode;
   wire        par;
   wire        is_dis;
   wire        is_rst;
   wire        is_frc;
   wire        is_qui;
   wire        is_cs;
   wire        is_ss;
   wire        is_emu;
   wire        protd;
   wire        go;
   wire        core_clear;
   wire        adr_ctl;
   wire        adr_sts;
   wire        adr_msk;
   wire        adr_lat;

   // Bus qualifiers; a request counts once, in the cycle before its ack
   assign wb_req   = wb_cyc_i & wb_stb_i & ~ack_r;
   assign wb_wr    = wb_req & wb_we_i;
   assign busy     = (state_r != S_IDLE);
   // A second instruction while one is in flight is dropped, not queued
   assign instr_wr = wb_wr & (wb_adr_i == `EM_OFS_INSTR) & ~busy;

   // Register address decode for writes
   assign adr_ctl  = (wb_adr_i == `EM_OFS_CONTROL);
   assign adr_sts  = (wb_adr_i == `EM_OFS_STATUS);
   assign adr_msk  = (wb_adr_i == `EM_OFS_MASK);
   assign adr_lat  = (wb_adr_i == `EM_OFS_LATCH);

   // Instruction word decode; low bits carry a register or event number
   assign op       = wb_dat_i[15:0];
   assign sup_mode = ctl_r[`EM_CTL_SUPER];
   assign par      = ctl_r[`EM_CTL_PAR];
   assign is_dis   = (op[15:3] == `EM_OPH_DISABLE);
   assign is_rst   = (op[15:3] == `EM_OPH_RESTORE);
   assign is_frc   = (op[15:4] == `EM_OPH_FORCE);
   assign is_qui   = (op == `EM_OP_QUIESCE);
   assign is_cs    = (op == `EM_OP_CSYNC);
   assign is_ss    = (op == `EM_OP_SSYNC);
   assign is_emu   = (op == `EM_OP_EMUFORCE);
   // Protected instructions need supervisor mode
   assign protd    = is_dis | is_rst | is_qui | is_frc;
   // Shared issue slot flagged: nothing executes
   assign go       = instr_wr & ~par & ~(protd & ~sup_mode);
   // Core settled once stores drained and no speculation is open
   assign core_clear = store_buf_empty & ~spec_pending;

   // Single-cycle ack; drops the cycle after it is given
   assign wb_ack_o = ack_r;
   always @(posedge clk) begin
      if (rst)
         ack_r <= 1'b0;
      else
         ack_r <= wb_req;
   end

   // Drain requests follow the sync state; store buffer drains in both syncs
   assign store_drain = (state_r == S_CSYNC);
   assign write_drain = (state_r == S_WBUF);
   // Issue held while any instruction here is in flight or quiesced
   assign issue_stall = busy | quiesced;
   // Loads may pass older stores, but not across a sync in progress
   assign load_pass_ok = ~busy;
   // Stores commit only when nothing speculative is ahead
   assign store_commit_ok = ~spec_pending & ~busy;

   // Next state
   always @* begin
      state_nxt = state_r;
      case (state_r)
         // Syncs and quiesce share the core drain; force-event counts down
         S_IDLE: begin
            if (go & (is_cs | is_ss | is_qui))
               state_nxt = S_CSYNC;
            else if (go & is_frc)
               state_nxt = S_RAISE;
         end
         // Core sync ends here; the others go on to the write buffers
         S_CSYNC: begin
            if (core_clear)
               state_nxt = (instr_r == `EM_OP_CSYNC) ? S_IDLE : S_WBUF;
         end
         // Write buffers empty before the system is asked
         S_WBUF: begin
            if (write_buf_empty)
               state_nxt = (instr_r == `EM_OP_SSYNC) ? S_REQ : S_QUIET;
         end
         // No timeout: a silent system side stalls issue for good
         S_REQ: begin
            if (sync_ack)
               state_nxt = S_IDLE;
         end
         // Hard wake pin or soft wake bit, whichever comes first
         S_QUIET: begin
            if (wake_event | ctl_r[`EM_CTL_WAKE])
               state_nxt = S_IDLE;
         end
         // Latch bit is set as this state is left
         S_RAISE: begin
            if (wb_cnt_r == 2'd0)
               state_nxt = S_IDLE;
         end
         // Unused codes fall back to idle
         default: state_nxt = S_IDLE;
      endcase
   end

   // Main sequencer and architectural state
   always @(posedge clk) begin
      if (rst) begin
         state_r <= S_IDLE;
         instr_r <= 16'h0000;
         interrupt_mask_register_r <= `EM_MASK_RST;
         interrupt_latch_register_r <= 16'h0000;
         ctl_r <= `EM_CTL_RST;
         result_r <= 16'h0000;
         prot_sticky_r <= 1'b0;
         illpar_r <= 1'b0;
         event_number_immediate_r <= 4'h0;
         wb_cnt_r <= 2'd0;
         sync_req <= 1'b0;
         quiesced <= 1'b0;
         emu_trap <= 1'b0;
         prot_exc <= 1'b0;
         resume_step <= 16'h0000;
         quiet_pending_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         emu_trap <= 1'b0;
         prot_exc <= 1'b0;
         // Hardware events latch; a set wins over a software clear
         if (wb_wr & adr_lat & wb_sel_i[0])
            interrupt_latch_register_r <= (interrupt_latch_register_r & ~wb_dat_i[15:0])
                                          | hw_events;
         else
            interrupt_latch_register_r <= interrupt_latch_register_r | hw_events;

         // Plain register writes
         if (wb_wr & adr_ctl)
            ctl_r <= wb_dat_i[3:0];
         if (wb_wr & adr_msk)
            interrupt_mask_register_r <= wb_dat_i[15:0];

         // Sticky flags clear by writing ones; a new event below still wins
         if (wb_wr & adr_sts) begin
            prot_sticky_r <= prot_sticky_r & ~wb_dat_i[`EM_ST_PROT];
            illpar_r <= illpar_r & ~wb_dat_i[`EM_ST_ILLPAR];
         end

         // Refused instructions leave a sticky trace for software
         if (instr_wr & par)
            illpar_r <= 1'b1;
         if (instr_wr & ~par & protd & ~sup_mode) begin
            prot_exc <= 1'b1;
            prot_sticky_r <= 1'b1;
         end
         if (go) begin
            instr_r <= op;
            result_r <= 16'h0000;
            if (is_emu & ctl_r[`EM_CTL_EMU_EN])
               emu_trap <= 1'b1;
            if (is_dis)
               interrupt_mask_register_r <= 16'h0000;
            if (is_rst)
               interrupt_mask_register_r <= dreg_r[op[2:0]][15:0];
            if (is_frc) begin
               event_number_immediate_r <= op[3:0];
               wb_cnt_r <= 2'd`EM_WB_DEPTH - 2'd1;
            end
            quiet_pending_r <= is_qui;
         end

         // Write-back countdown for force-event
         if ((state_r == S_RAISE) & (wb_cnt_r != 2'd0))
            wb_cnt_r <= wb_cnt_r - 2'd1;
         // At write-back; this bit write overrides the latch update above
         if ((state_r == S_RAISE) & (wb_cnt_r == 2'd0)) begin
            // Exception and emulation slots, and reserved slot 4, stay untouched
            if ((event_number_immediate_r != 4'd`EM_EV_EMU) &
                (event_number_immediate_r != 4'd`EM_EV_EXC) &
                (event_number_immediate_r != 4'd4))
               interrupt_latch_register_r[event_number_immediate_r] <= 1'b1;
         end

         // Flags follow the next state, so they line up with it
         sync_req <= (state_nxt == S_REQ);
         quiesced <= (state_nxt == S_QUIET);

         // Leaving sleep counts one resume and drops the soft wake
         if ((state_r == S_QUIET) & (state_nxt == S_IDLE)) begin
            resume_step <= resume_step + 16'h0001;
            quiet_pending_r <= 1'b0;
            ctl_r[`EM_CTL_WAKE] <= 1'b0;
         end
         // Done code for syncs and force-event; sleep reports none
         if ((state_r != S_IDLE) & (state_nxt == S_IDLE) & (state_r != S_QUIET))
            result_r <= 16'h0001;
      end
   end

   // Data register file; disable saves the old mask into its named register
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_dreg
         always @(posedge clk) begin
            if (rst)
               dreg_r[gi] <= 32'h00000000;
            else if (go & is_dis & (op[2:0] == gi))
               dreg_r[gi] <= {16'h0000, interrupt_mask_register_r};
            else if (wb_wr & (wb_adr_i == (`EM_OFS_DREG0 + 8'd4 * gi)))
               dreg_r[gi] <= wb_dat_i;
         end
      end
   endgenerate

   // Event priority: emulation first, then reset, NMI, exception, then masked
   integer k;
   reg [15:0] pend;
   always @* begin
      pend = interrupt_latch_register_r & (interrupt_mask_register_r | 16'h001f);
      event_take = 4'h0;
      event_valid = 1'b0;
      for (k = 15; k >= 0; k = k - 1) begin
         if (pend[k]) begin
            event_take = k[3:0];
            event_valid = 1'b1;
         end
      end
      if (emu_trap) begin
         event_take = 4'd`EM_EV_EMU;
         event_valid = 1'b1;
      end
   end

   // Register read mux
   always @(posedge clk) begin
      if (rst)
         wb_dat_o <= 32'h00000000;
      else if (wb_req & ~wb_we_i) begin
         case (wb_adr_i)
            `EM_OFS_INSTR:   wb_dat_o <= {16'h0000, instr_r};
            `EM_OFS_CONTROL: wb_dat_o <= {28'h0000000, ctl_r};
            `EM_OFS_STATUS:  wb_dat_o <= {26'h0000000, illpar_r, sync_req, emu_trap,
                                          prot_sticky_r, quiesced, busy};
            `EM_OFS_MASK:    wb_dat_o <= {16'h0000, interrupt_mask_register_r};
            `EM_OFS_LATCH:   wb_dat_o <= {16'h0000, interrupt_latch_register_r};
            `EM_OFS_RESULT:  wb_dat_o <= {16'h0000, result_r};
            default: begin
               if ((wb_adr_i >= `EM_OFS_DREG0) && (wb_adr_i < 8'h40))
                  wb_dat_o <= dreg_r[wb_adr_i[4:2]];
               else
                  wb_dat_o <= 32'h00000000;
            end
         endcase
      end
   end

endmodule
`default_nettype wire

// ### verif/em_props.sv
// Port-level checker for the event-management unit
`timescale 1ns/1ps
`default_nettype none
module em_props (
   input wire logic clk,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic write_buf_empty,
   input wire logic wake_event,
   input wire logic sync_ack,
   input wire logic sync_req,
   input wire logic issue_stall,
   input wire logic quiesced,
   input wire logic emu_trap,
   input wire logic prot_exc
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // A request taken, then its one-cycle answer
   sequence bus_take;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence ack_pulse;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   AST_ACK_ANSWER: assert property (bus_take |=> ack_pulse)
      else $error("bus answer missing or too long");
   AST_SYNC_HOLD: assert property (sync_req && !sync_ack |=> sync_req)
      else $error("sync request dropped before ack");
   AST_SYNC_STALL: assert property (sync_req |-> issue_stall)
      else $error("issue not stalled during sync");
   AST_SYNC_DRAINED: assert property ($rose(sync_req) |-> $past(write_buf_empty))
      else $error("sync request before write drain");
   AST_EMU_PULSE: assert property (emu_trap |=> !emu_trap)
      else $error("emulation trap longer than a cycle");
   AST_PROT_PULSE: assert property (prot_exc |=> !prot_exc)
      else $error("protection pulse longer than a cycle");
   AST_QUIET_STALL: assert property (quiesced |-> issue_stall)
      else $error("issue not stalled while quiesced");
   // Soft wake comes over the bus, so only idle bus cycles are judged
   AST_QUIET_HOLD: assert property (quiesced && !wake_event && !wb_cyc_i |=> quiesced)
      else $error("quiesce left without wake");
endmodule
bind event_management_instruction_unit em_props u_props (.clk(clk), .rst(rst),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
   .write_buf_empty(write_buf_empty), .wake_event(wake_event), .sync_ack(sync_ack),
   .sync_req(sync_req), .issue_stall(issue_stall), .quiesced(quiesced),
   .emu_trap(emu_trap), .prot_exc(prot_exc));
`default_nettype wire

// ### verif/sync_responder.sv
// System side that acknowledges sync requests after a chosen delay
`timescale 1ns/1ps
`default_nettype none
module sync_responder (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       sync_req,
   input  wire logic [3:0] delay,
   output var  logic       sync_ack
);
   logic [3:0] wait_r;
   // Ack is held until the request falls, so a slow sampler cannot miss it
   always @(posedge clk) begin
      if (rst || !sync_req) begin
         wait_r   <= 4'h0;
         sync_ack <= 1'b0;
      end else if (wait_r >= delay) begin
         sync_ack <= 1'b1;
      end else begin
         wait_r <= wait_r + 4'h1;
      end
   end
endmodule
`default_nettype wire

// ### verif/testbench.sv
// Self-checking bench for the event-management unit
`timescale 1ns/1ps
`default_nettype none
`include "event_mgmt_defines.vh"
module testbench;
   logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic        sbe = 1'b1, wbe = 1'b1, spec = 1'b0, wake = 1'b0, lp = 1'b0, sp = 1'b0;
   logic        ack, sreq, sack, quiet, emulation_event, prot;
   logic        sdr, wdr, stall, lpo, sco, evv;
   logic [3:0]  evt;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0, rdat, q;
   logic [15:0] step, m, s0;
   logic [3:0]  dly = 4'h1;
   int          fail_count = 0, comparisons = 0, emu_seen = 0, s, r;
   event_management_instruction_unit dut (.clk(clk), .rst(rst), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .store_buf_empty(sbe), .write_buf_empty(wbe),
      .spec_pending(spec), .load_pending(lp), .store_pending(sp),
      .hw_event_in_n_unused_tie(1'b0), .hw_events(16'h0000), .wake_event(wake),
      .sync_ack(sack), .sync_req(sreq), .store_drain(sdr), .write_drain(wdr),
      .issue_stall(stall), .load_pass_ok(lpo), .store_commit_ok(sco), .quiesced(quiet),
      .emu_trap(emulation_event), .prot_exc(prot), .event_take(evt), .event_valid(evv),
      .resume_step(step));
   sync_responder sys (.clk(clk), .rst(rst), .sync_req(sreq), .delay(dly), .sync_ack(sack));
   always #12.5 clk = ~clk;
   // Random traffic on the unused order hints, and a trap counter
   always @(posedge clk) begin
      lp <= $urandom;
      sp <= $urandom;
      if (emulation_event === 1'b1) emu_seen <= emu_seen + 1;
   end
   // Classic cycle: hold everything until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do @(posedge clk); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wait_idle();
      for (int i = 0; i < 60; i++) begin
         wb(1'b0, `EM_OFS_STATUS, 32'h0);
         if (q[`EM_ST_BUSY] === 1'b0) break;
      end
   endtask
   // Latch bit expected after force-event n; reserved numbers set nothing
   function automatic logic [31:0] raise_exp(input int n);
      return (n == 0 || n == 3 || n == 4) ? 32'h0 : 32'h1 << n;
   endfunction
   task automatic finish_test();
      if (fail_count == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge clk);
      fail_count++;
      finish_test();
   end
   initial begin
      void'($urandom(32'hf15ced39));
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      wb(0, `EM_OFS_MASK, 0);
      chk(q, {16'h0, `EM_MASK_RST});
      wb(0, `EM_OFS_CONTROL, 0);
      chk(q, {28'h0, `EM_CTL_RST});
      wb(1, 8'h80, 32'hffff_ffff);
      wb(0, 8'h80, 0);
      chk(q, 0);
      // Save and restore the mask through every data register
      for (r = 0; r < 8; r++) begin
         m = $urandom | 16'h001f;
         wb(1, `EM_OFS_MASK, {16'h0, m});
         wb(1, `EM_OFS_INSTR, {16'h0, `EM_OPH_DISABLE, r[2:0]});
         wait_idle();
         wb(0, 8'(`EM_OFS_DREG0 + 4 * r), 0);
         chk(q, {16'h0, m});
         wb(1, `EM_OFS_INSTR, {16'h0, `EM_OPH_RESTORE, r[2:0]});
         wait_idle();
         wb(0, `EM_OFS_MASK, 0);
         chk(q, {16'h0, m});
      end
      // Every event number, reserved ones included
      for (r = 0; r < 16; r++) begin
         wb(1, `EM_OFS_LATCH, 32'hffff);
         wb(1, `EM_OFS_INSTR, {16'h0, `EM_OPH_FORCE, r[3:0]});
         repeat (`EM_WB_DEPTH + 1) @(posedge clk);
         wb(0, `EM_OFS_LATCH, 0);
         chk(q, raise_exp(r));
         if (r == 1 || r == 2) chk({evv, evt}, {1'b1, r[3:0]});
      end
      // User mode refuses protected instructions
      wb(1, `EM_OFS_MASK, 32'hff1f);
      wb(1, `EM_OFS_CONTROL, 0);
      wb(0, `EM_OFS_STATUS, 0);
      chk(q[`EM_ST_PROT], 1'b0);
      wb(1, `EM_OFS_INSTR, {16'h0, `EM_OPH_DISABLE, 3'h5});
      wait_idle();
      wb(0, `EM_OFS_MASK, 0);
      chk(q, 32'hff1f);
      wb(0, `EM_OFS_STATUS, 0);
      chk(q[`EM_ST_PROT], 1'b1);
      wb(1, `EM_OFS_STATUS, 32'h1 << `EM_ST_PROT);
      wb(1, `EM_OFS_LATCH, 32'hffff);
      wb(0, `EM_OFS_STATUS, 0);
      chk(q[`EM_ST_PROT], 1'b0);
      wb(1, `EM_OFS_INSTR, {16'h0, `EM_OPH_FORCE, 4'h9});
      repeat (`EM_WB_DEPTH + 2) @(posedge clk);
      wb(0, `EM_OFS_LATCH, 0);
      chk(q, 0);
      wb(0, `EM_OFS_STATUS, 0);
      chk(q[`EM_ST_PROT], 1'b1);
      // Force emulation disabled, then enabled
      wb(1, `EM_OFS_CONTROL, 32'h1);
      s = emu_seen;
      wb(1, `EM_OFS_INSTR, {16'h0, `EM_OP_EMUFORCE});
      repeat (6) @(posedge clk);
      chk(32'(emu_seen - s), 0);
      wb(1, `EM_OFS_CONTROL, 32'h3);
      wb(1, `EM_OFS_INSTR, {16'h0, `EM_OP_EMUFORCE});
      repeat (6) @(posedge clk);
      chk(32'(emu_seen - s), 1);
      // Shared issue slot refuses the instruction and flags it
      wb(1, `EM_OFS_CONTROL, 32'h9);
      wb(1, `EM_OFS_INSTR, {16'h0, `EM_OPH_DISABLE, 3'h2});
      wb(0, `EM_OFS_STATUS, 0);
      chk(q[`EM_ST_ILLPAR], 1'b1);
      chk(q[`EM_ST_BUSY], 1'b0);
      wb(1, `EM_OFS_CONTROL, 32'h1);
      // System sync waits on speculation and write drain before requesting
      spec <= 1'b1;
      wbe <= 1'b0;
      dly <= 4'($urandom_range(1, 8));
      wb(1, `EM_OFS_INSTR, {16'h0, `EM_OP_SSYNC});
      repeat (10) @(posedge clk);
      chk(sreq, 1'b0);
      chk({sdr, stall, lpo, sco}, 4'b1100);
      spec <= 1'b0;
      repeat (10) @(posedge clk);
      chk(sreq, 1'b0);
      chk({sdr, wdr}, 2'b01);
      wbe <= 1'b1;
      wait_idle();
      wb(0, `EM_OFS_RESULT, 0);
      chk(q, 1);
      chk({stall, lpo, sco}, 3'b011);
      // Quiesce holds until wake, then the resume step advances by one
      s0 = step;
      wb(1, `EM_OFS_INSTR, {16'h0, `EM_OP_QUIESCE});
      repeat (20) @(posedge clk);
      chk(quiet, 1'b1);
      wake <= 1'b1;
      @(posedge clk);
      wake <= 1'b0;
      repeat (4) @(posedge clk);
      chk(quiet, 1'b0);
      chk(step, s0 + 16'h1);
      finish_test();
   end
endmodule
`default_nettype wire
